//--- core/seq_pkg.sv
// sequencer register bank: port addresses, indices, field positions, reset values
// assumes the host bus logic runs on the same clock as the sequencer
package seq_pkg;

	// host i/o ports
	localparam logic [15:0] INDEX_PORT_ADDR = 16'h03c4;
	localparam logic [15:0] DATA_PORT_ADDR  = 16'h03c5;

	// indices within the data port
	localparam logic [4:0] IDX_RESET_CTRL = 5'h00;
	localparam logic [4:0] IDX_CLK_MODE   = 5'h01;
	localparam logic [4:0] IDX_PLANE_MASK = 5'h02;
	localparam logic [4:0] IDX_FONT_SEL   = 5'h03;
	localparam logic [4:0] IDX_MEM_MODE   = 5'h04;

	// defined bits of each register, reserved bits read zero
	localparam logic [7:0] INDEX_MASK      = 8'h1f;
	localparam logic [7:0] RESET_CTRL_MASK = 8'h03;
	localparam logic [7:0] CLK_MODE_MASK   = 8'h3d;
	localparam logic [7:0] PLANE_MASK_MASK = 8'h0f;
	localparam logic [7:0] FONT_SEL_MASK   = 8'h3f;
	localparam logic [7:0] MEM_MODE_MASK   = 8'h0e;

	// values after reset
	localparam logic [4:0] INDEX_RST      = 5'h00;
	localparam logic [7:0] RESET_CTRL_RST = 8'h03;
	localparam logic [7:0] CLK_MODE_RST   = 8'h00;
	localparam logic [7:0] PLANE_MASK_RST = 8'h0f;
	localparam logic [7:0] FONT_SEL_RST   = 8'h00;
	localparam logic [7:0] MEM_MODE_RST   = 8'h00;

	// field positions
	localparam int RST_SYNC_BIT   = 1;
	localparam int RST_ASYNC_BIT  = 0;
	localparam int CM_SCREEN_OFF  = 5;
	localparam int CM_SHIFT4      = 4;
	localparam int CM_DOT_DIV2    = 3;
	localparam int CM_SHIFT_LOAD  = 2;
	localparam int CM_DOT8        = 0;
	localparam int FS_A_MSB       = 5;
	localparam int FS_B_MSB       = 4;
	localparam int FS_A_HI        = 3;
	localparam int FS_A_LO        = 2;
	localparam int FS_B_HI        = 1;
	localparam int FS_B_LO        = 0;
	localparam int MM_CHAIN4      = 3;
	localparam int MM_ODD_EVEN    = 2;
	localparam int MM_EXT_MEM     = 1;
	localparam int ATTR_FONT_AB   = 3;
	localparam int ATTR_FONT_PL   = 4;

	// character cell widths in dots, minus one
	localparam logic [3:0] CHAR_LAST_DOT9 = 4'h8;
	localparam logic [3:0] CHAR_LAST_DOT8 = 4'h7;
	// serializer load spacing in character clocks, minus one
	localparam logic [1:0] LOAD_LAST_EVERY1 = 2'h0;
	localparam logic [1:0] LOAD_LAST_EVERY2 = 2'h1;
	localparam logic [1:0] LOAD_LAST_EVERY4 = 2'h3;

	typedef enum logic [1:0] {
		ST_HALT = 2'b01,
		ST_RUN  = 2'b10
	} seq_state_t;

endpackage : seq_pkg

//--- core/char_clock_gen.sv
// dot, character and serializer load timing of the sequencer
// assumes run is decoded from flip-flops on mclk; config fields are levels on mclk
`timescale 1ns/100ps
module char_clock_gen
	import seq_pkg::*;
(
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic run,
	input  wire logic cfg_div2,
	input  wire logic cfg_dot8,
	input  wire logic cfg_shift4,
	input  wire logic cfg_shift2,
	output logic      dot_tick,
	output logic      char_tick,
	output logic      serial_load,
	output logic      fetch_32bit
);

	typedef struct packed {
		logic       div_ph;
		logic [3:0] dot_cnt;
		logic [1:0] load_cnt;
		logic       div2;
		logic       dot8;
		logic       shift4;
		logic       shift2;
		logic       dot_tick;
		logic       char_tick;
		logic       serial_load;
	} ccg_state_t;

	ccg_state_t s_q;
	ccg_state_t s_d;
	logic       dot_en;
	logic       char_end;
	logic [3:0] last_dot;
	logic [1:0] last_load;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d = s_q;
		dot_en = run && (!s_q.div2 || s_q.div_ph);
		last_dot = s_q.dot8 ? CHAR_LAST_DOT8 : CHAR_LAST_DOT9;
		if (s_q.shift4) begin
			last_load = LOAD_LAST_EVERY4;
		end else if (s_q.shift2) begin
			last_load = LOAD_LAST_EVERY2;
		end else begin
			last_load = LOAD_LAST_EVERY1;
		end
		char_end = dot_en && (s_q.dot_cnt >= last_dot);
		s_d.dot_tick = dot_en;
		s_d.char_tick = char_end;
		s_d.serial_load = char_end && (s_q.load_cnt >= last_load);
		if (!run) begin
			// halted sequencer is cleared and takes new config at once
			s_d.div_ph = 1'b0;
			s_d.dot_cnt = '0;
			s_d.load_cnt = '0;
		end else begin
			s_d.div_ph = !s_q.div_ph;
			if (char_end) begin
				s_d.dot_cnt = '0;
				s_d.load_cnt = (s_q.load_cnt >= last_load) ? 2'h0 : s_q.load_cnt + 2'h1;
			end else if (dot_en) begin
				s_d.dot_cnt = s_q.dot_cnt + 4'h1;
			end
		end
		// config is taken at a character boundary, or on every cycle while halted
		if (!run || char_end) begin
			s_d.div2 = cfg_div2;
			s_d.dot8 = cfg_dot8;
			s_d.shift4 = cfg_shift4;
			s_d.shift2 = cfg_shift2;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dot_tick = s_q.dot_tick;
	assign char_tick = s_q.char_tick;
	assign serial_load = s_q.serial_load;
	assign fetch_32bit = s_q.shift4;

endmodule : char_clock_gen

//--- core/plane_steer.sv
// steers a processor memory write onto the four plane write enables
// assumes mem_wr and addr_lo come from logic on mclk
`timescale 1ns/100ps
module plane_steer
	import seq_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       mem_wr,
	input  wire logic [1:0] addr_lo,
	input  wire logic [3:0] plane_mask,
	input  wire logic       chain4,
	input  wire logic       seq_planes,
	output logic [3:0]      plane_wr_en
);

	typedef struct packed {
		logic [3:0] wr_en;
	} ps_state_t;

	ps_state_t  s_q;
	ps_state_t  s_d;
	logic [3:0] sel;

	////////////////////////////////////////////////////////////////////////////
	// plane decode, chain four over odd/even over mask alone
	always_comb begin
		s_d = s_q;
		if (chain4) begin
			sel = 4'h1 << addr_lo;
		end else if (!seq_planes) begin
			sel = addr_lo[0] ? 4'ha : 4'h5;
		end else begin
			sel = 4'hf;
		end
		s_d.wr_en = mem_wr ? (sel & plane_mask) : 4'h0;
	end

	// state register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign plane_wr_en = s_q.wr_en;

endmodule : plane_steer

//--- core/vga_sequencer_control.sv
// sequencer register bank: index/data port pair, reset control, timing and plane steering
// assumes host i/o strobes, memory writes and attribute bytes arrive on mclk
`timescale 1ns/100ps
module vga_sequencer_control
	import seq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic [7:0]       io_rdata,
	output logic             io_rdata_valid,
	input  wire logic        cpu_mem_wr,
	input  wire logic [1:0]  vmem_addr_lo,
	input  wire logic [7:0]  attr_byte,
	input  wire logic [1:0]  ext_font_plane_sel,
	output logic [3:0]       plane_wr_en,
	output logic             mem_extended,
	output logic             seq_running,
	output logic             screen_blank,
	output logic             dot_tick,
	output logic             char_tick,
	output logic             serial_load,
	output logic             fetch_32bit,
	output logic [2:0]       font_block,
	output logic             font_plane
);

	typedef struct packed {
		logic [4:0] index;
		logic [7:0] reset_ctrl;
		logic [7:0] clk_mode;
		logic [7:0] plane_mask;
		logic [7:0] font_sel;
		logic [7:0] mem_mode;
		seq_state_t state;
		logic [7:0] rdata;
		logic       rvalid;
		logic       blank;
		logic [2:0] font_block;
		logic       font_plane;
		logic       ext_mem;
		logic       running;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;
	logic       hit_index;
	logic       hit_data;
	logic       run;
	logic       cc_char_tick;
	logic [2:0] map_num;
	logic [7:0] data_rd;

	////////////////////////////////////////////////////////////////////////////
	// font map number to 8 KB block index, numbers run even blocks then odd
	function automatic logic [2:0] map_to_block(input logic [2:0] num);
		map_to_block = {num[1:0], num[2]};
	endfunction : map_to_block

	////////////////////////////////////////////////////////////////////////////
	// register file, run control and font selection
	always_comb begin
		s_d = s_q;
		hit_index = (io_addr == INDEX_PORT_ADDR);
		hit_data = (io_addr == DATA_PORT_ADDR);

		// data port readback, reserved bits and unused indices read zero
		unique case (s_q.index)
			IDX_RESET_CTRL: data_rd = s_q.reset_ctrl & RESET_CTRL_MASK;
			IDX_CLK_MODE:   data_rd = s_q.clk_mode & CLK_MODE_MASK;
			IDX_PLANE_MASK: data_rd = s_q.plane_mask & PLANE_MASK_MASK;
			IDX_FONT_SEL:   data_rd = s_q.font_sel & FONT_SEL_MASK;
			IDX_MEM_MODE:   data_rd = s_q.mem_mode & MEM_MODE_MASK;
			default:        data_rd = 8'h00;
		endcase

		// host writes; reserved bits are dropped so they always read zero
		if (io_wr && hit_index) begin
			s_d.index = io_wdata[4:0];
		end
		if (io_wr && hit_data) begin
			unique case (s_q.index)
				IDX_RESET_CTRL: s_d.reset_ctrl = io_wdata & RESET_CTRL_MASK;
				IDX_CLK_MODE:   s_d.clk_mode = io_wdata & CLK_MODE_MASK;
				IDX_PLANE_MASK: s_d.plane_mask = io_wdata & PLANE_MASK_MASK;
				IDX_FONT_SEL:   s_d.font_sel = io_wdata & FONT_SEL_MASK;
				IDX_MEM_MODE:   s_d.mem_mode = io_wdata & MEM_MODE_MASK;
				default:        s_d.index = s_q.index;
			endcase
		end

		// read answer one cycle after the strobe
		s_d.rvalid = io_rd && (hit_index || hit_data);
		if (io_rd && hit_index) begin
			s_d.rdata = {3'h0, s_q.index};
		end else if (io_rd && hit_data) begin
			s_d.rdata = data_rd;
		end else begin
			s_d.rdata = 8'h00;
		end

		// run control: async bit halts now, sync bit halts at character end
		unique case (s_q.state)
			ST_RUN: begin
				if (!s_q.reset_ctrl[RST_ASYNC_BIT]) begin
					s_d.state = ST_HALT;
				end else if (!s_q.reset_ctrl[RST_SYNC_BIT] && cc_char_tick) begin
					s_d.state = ST_HALT;
				end
			end
			ST_HALT: begin
				if (s_q.reset_ctrl[RST_ASYNC_BIT] && s_q.reset_ctrl[RST_SYNC_BIT]) begin
					s_d.state = ST_RUN;
				end
			end
		endcase
		s_d.running = (s_d.state == ST_RUN);

		// picture blanked when screen off or halted; syncs are not gated here
		s_d.blank = s_q.clk_mode[CM_SCREEN_OFF] || (s_q.state != ST_RUN);

		// font map: attribute bit 3 picks A or B only with extended memory set
		if (s_q.mem_mode[MM_EXT_MEM] && !attr_byte[ATTR_FONT_AB]) begin
			map_num = {s_q.font_sel[FS_B_MSB], s_q.font_sel[FS_B_HI],
				s_q.font_sel[FS_B_LO]};
		end else begin
			map_num = {s_q.font_sel[FS_A_MSB], s_q.font_sel[FS_A_HI],
				s_q.font_sel[FS_A_LO]};
		end
		s_d.font_block = map_to_block(map_num);
		s_d.font_plane = attr_byte[ATTR_FONT_PL] ? ext_font_plane_sel[1]
			: ext_font_plane_sel[0];
		s_d.ext_mem = s_q.mem_mode[MM_EXT_MEM];
	end

	// state register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q.index      <= INDEX_RST;
			s_q.reset_ctrl <= RESET_CTRL_RST;
			s_q.clk_mode   <= CLK_MODE_RST;
			s_q.plane_mask <= PLANE_MASK_RST;
			s_q.font_sel   <= FONT_SEL_RST;
			s_q.mem_mode   <= MEM_MODE_RST;
			s_q.state      <= ST_HALT;
			s_q.rdata      <= 8'h00;
			s_q.rvalid     <= 1'b0;
			s_q.blank      <= 1'b1;
			s_q.font_block <= 3'h0;
			s_q.font_plane <= 1'b0;
			s_q.ext_mem    <= 1'b0;
			s_q.running    <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// async reset bit gates the timing at once, without waiting for the state
	assign run = (s_q.state == ST_RUN) && s_q.reset_ctrl[RST_ASYNC_BIT];

	////////////////////////////////////////////////////////////////////////////
	// character clock and serializer timing
	char_clock_gen u_ccg (
		.mclk        (mclk),
		.nrst        (nrst),
		.run         (run),
		.cfg_div2    (s_q.clk_mode[CM_DOT_DIV2]),
		.cfg_dot8    (s_q.clk_mode[CM_DOT8]),
		.cfg_shift4  (s_q.clk_mode[CM_SHIFT4]),
		.cfg_shift2  (s_q.clk_mode[CM_SHIFT_LOAD]),
		.dot_tick    (dot_tick),
		.char_tick   (cc_char_tick),
		.serial_load (serial_load),
		.fetch_32bit (fetch_32bit)
	);

	// plane write steering
	plane_steer u_ps (
		.mclk        (mclk),
		.nrst        (nrst),
		.mem_wr      (cpu_mem_wr),
		.addr_lo     (vmem_addr_lo),
		.plane_mask  (s_q.plane_mask[3:0]),
		.chain4      (s_q.mem_mode[MM_CHAIN4]),
		.seq_planes  (s_q.mem_mode[MM_ODD_EVEN]),
		.plane_wr_en (plane_wr_en)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs, each from a flip-flop
	assign char_tick = cc_char_tick;
	assign io_rdata = s_q.rdata;
	assign io_rdata_valid = s_q.rvalid;
	assign mem_extended = s_q.ext_mem;
	assign seq_running = s_q.running;
	assign screen_blank = s_q.blank;
	assign font_block = s_q.font_block;
	assign font_plane = s_q.font_plane;

endmodule : vga_sequencer_control

//--- tb/seq_ctrl_props.sv
// checker: port answers, plane pulses, halt, timing and font plane
// assumes binding to the sequencer top; one clock, async active-low reset
`timescale 1ns/100ps
module seq_ctrl_props
	import seq_pkg::*;
(
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [15:0] io_addr,
	input wire logic        io_rd,
	input wire logic        io_rdata_valid,
	input wire logic        cpu_mem_wr,
	input wire logic [3:0]  plane_wr_en,
	input wire logic        seq_running,
	input wire logic        screen_blank,
	input wire logic        dot_tick,
	input wire logic        char_tick,
	input wire logic        serial_load,
	input wire logic [7:0]  attr_byte,
	input wire logic [1:0]  ext_font_plane_sel,
	input wire logic        font_plane
);
	logic port_rd;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	// read strobe on either port, settled halt
	assign port_rd = io_rd && (io_addr == INDEX_PORT_ADDR || io_addr == DATA_PORT_ADDR);
	sequence s_port_rd;
		port_rd;
	endsequence
	sequence s_halt3;
		!seq_running [*3];
	endsequence
	// answers, pulses, halt and font plane
	a_read_answer: assert property (s_port_rd |=> io_rdata_valid)
		else $error("port read not answered");
	a_no_stray: assert property (!port_rd |=> !io_rdata_valid)
		else $error("answer without port read");
	a_plane_idle: assert property (!cpu_mem_wr |=> plane_wr_en == 4'h0)
		else $error("plane enable without write");
	a_load_char: assert property (serial_load |-> char_tick)
		else $error("load off a character boundary");
	a_char_gap: assert property (char_tick |=> !char_tick [*7])
		else $error("character shorter than eight dots");
	a_halt_blank: assert property (!seq_running |=> screen_blank)
		else $error("halted but not blanked");
	a_halt_still: assert property (s_halt3 |-> !dot_tick && !serial_load)
		else $error("ticks while halted");
	a_font_plane: assert property ($past(nrst) |-> font_plane ==
		($past(attr_byte[ATTR_FONT_PL]) ? $past(ext_font_plane_sel[1])
		: $past(ext_font_plane_sel[0])))
		else $error("font plane wrong");
endmodule : seq_ctrl_props
bind vga_sequencer_control seq_ctrl_props chk_u (
	.mclk(mclk), .nrst(nrst), .io_addr(io_addr), .io_rd(io_rd),
	.io_rdata_valid(io_rdata_valid), .cpu_mem_wr(cpu_mem_wr),
	.plane_wr_en(plane_wr_en), .seq_running(seq_running),
	.screen_blank(screen_blank), .dot_tick(dot_tick), .char_tick(char_tick),
	.serial_load(serial_load), .attr_byte(attr_byte),
	.ext_font_plane_sel(ext_font_plane_sel), .font_plane(font_plane)
);

//--- tb/host_io_model.sv
// host model: master of the index/data i/o port pair
// assumes strobes sampled on rising mclk, read answer one cycle later
`timescale 1ns/100ps
module host_io_model (
	input  wire logic        mclk,
	output logic [15:0]      io_addr,
	output logic             io_wr,
	output logic             io_rd,
	output logic [7:0]       io_wdata,
	input  wire logic [7:0]  io_rdata,
	input  wire logic        io_rdata_valid
);
	// idle bus
	initial begin
		io_addr  = 16'h0000;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_wdata = 8'h00;
	end
	// write cycle; reserved bits zero unless a caller means otherwise
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		io_addr  <= a;
		io_wdata <= d;
		io_wr    <= 1'b1;
		@(posedge mclk);
		io_wr    <= 1'b0;
		io_wdata <= ~d; // released data stops holding the value
	endtask : wr
	// read cycle, answer taken one cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk);
		io_addr <= a;
		io_rd   <= 1'b1;
		@(posedge mclk);
		io_rd   <= 1'b0;
		@(posedge mclk);
		d = io_rdata;
		v = io_rdata_valid;
	endtask : rd
endmodule : host_io_model

//--- tb/testbench.sv
// testbench: registers, plane steering, clocks, fonts and run control
// assumes host_io_model as the i/o master and the bound checker
`timescale 1ns/100ps
module testbench
	import seq_pkg::*;
;
	logic        mclk, nrst, io_wr, io_rd, io_rdata_valid, cpu_mem_wr;
	logic        mem_extended, seq_running, screen_blank, dot_tick;
	logic        char_tick, serial_load, fetch_32bit, font_plane;
	logic [15:0] io_addr;
	logic [7:0]  io_wdata, io_rdata, attr_byte;
	logic [3:0]  plane_wr_en;
	logic [2:0]  font_block;
	logic [1:0]  vmem_addr_lo, ext_font_plane_sel;
	int          err_total = 0;
	int          num_checks = 0;
	always #4 mclk = ~mclk;
	vga_sequencer_control dut_u (
		.mclk(mclk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
		.cpu_mem_wr(cpu_mem_wr), .vmem_addr_lo(vmem_addr_lo), .attr_byte(attr_byte),
		.ext_font_plane_sel(ext_font_plane_sel), .plane_wr_en(plane_wr_en),
		.mem_extended(mem_extended), .seq_running(seq_running),
		.screen_blank(screen_blank), .dot_tick(dot_tick), .char_tick(char_tick),
		.serial_load(serial_load), .fetch_32bit(fetch_32bit),
		.font_block(font_block), .font_plane(font_plane));
	host_io_model host_u (
		.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));
	////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// indexed register write and read
	task automatic sr(input logic [4:0] i, input logic [7:0] d);
		host_u.wr(INDEX_PORT_ADDR, {3'h0, i});
		host_u.wr(DATA_PORT_ADDR, d);
	endtask : sr
	task automatic gr(input logic [4:0] i, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		host_u.wr(INDEX_PORT_ADDR, {3'h0, i});
		host_u.rd(DATA_PORT_ADDR, d, v);
		chk(d, e);
		chk({7'h0, v}, 8'h01);
	endtask : gr
	// cycles between char ticks, or loads, once the mode has settled
	task automatic gap(input logic ld, output logic [7:0] n);
		repeat (3) begin
			@(posedge mclk);
			for (int k = 0; k < 99 && (ld ? serial_load : char_tick) !== 1'b1; k++)
				@(posedge mclk);
		end
		n = 8'h00;
		do begin
			@(posedge mclk);
			n++;
		end while ((ld ? serial_load : char_tick) !== 1'b1 && n < 8'hf0);
	endtask : gap
	////////////////////////////////////////
	// reset values, all-ones readback, dead index and foreign port
	task automatic t_regs();
		logic [7:0] m [6] = '{RESET_CTRL_MASK, CLK_MODE_MASK, PLANE_MASK_MASK,
			FONT_SEL_MASK, MEM_MODE_MASK, 8'h00};
		logic [7:0] r [6] = '{RESET_CTRL_RST, CLK_MODE_RST, PLANE_MASK_RST,
			FONT_SEL_RST, MEM_MODE_RST, 8'h00};
		logic [7:0] d;
		logic       v;
		for (int i = 0; i < 6; i++) begin
			gr(5'(i), r[i]);
			sr(5'(i), m[i]);
			gr(5'(i), m[i]);
			sr(5'(i), r[i]);
		end
		host_u.wr(INDEX_PORT_ADDR, 8'h1f);
		host_u.rd(INDEX_PORT_ADDR, d, v);
		chk(d, INDEX_MASK);
		host_u.rd(16'h03c6, d, v);
		chk({v, d[6:0]}, 8'h00);
	endtask : t_regs
	// plane enables: rows of mode, mask, address, expected enables
	task automatic t_planes();
		logic [15:0] t [10] = '{16'h8f01, 16'h8f12, 16'h8f24, 16'h8f38, 16'h8530,
			16'h0f05, 16'h0f3a, 16'h4f2f, 16'h4606, 16'h0e24};
		foreach (t[i]) begin
			sr(IDX_MEM_MODE, {4'h0, t[i][15:12]});
			sr(IDX_PLANE_MASK, {4'h0, t[i][11:8]});
			@(posedge mclk);
			cpu_mem_wr   <= 1'b1;
			vmem_addr_lo <= t[i][5:4];
			@(posedge mclk);
			cpu_mem_wr   <= 1'b0;
			vmem_addr_lo <= ~t[i][5:4];
			@(posedge mclk);
			chk({4'h0, plane_wr_en}, {4'h0, t[i][3:0]});
		end
		sr(IDX_MEM_MODE, MEM_MODE_RST);
		sr(IDX_PLANE_MASK, PLANE_MASK_RST);
	endtask : t_planes
	// rows of mode, tick or load, cycles: dots times divider times spacing
	task automatic t_clocks();
		logic [19:0] t [7] = '{20'h00009, 20'h01008, 20'h08012, 20'h00109,
			20'h04112, 20'h14124, 20'h11120};
		logic [7:0]  n;
		foreach (t[i]) begin
			sr(IDX_CLK_MODE, t[i][19:12]);
			gap(t[i][8], n);
			chk(n, t[i][7:0]);
			chk({7'h0, fetch_32bit}, {7'h0, t[i][16]});
		end
		sr(IDX_CLK_MODE, CLK_MODE_RST);
	endtask : t_clocks
	// every map number written to A and B, both attribute and memory choices; block checked only for the map they pick
	task automatic t_fonts();
		logic [2:0] blk [8] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5, 3'h7};
		logic [2:0] a;
		logic [2:0] b;
		for (int i = 0; i < 8; i++) begin
			a = 3'(i);
			b = ~a;
			sr(IDX_FONT_SEL, {2'h0, a[2], b[2], a[1:0], b[1:0]});
			sr(IDX_MEM_MODE, {6'h0, a[0], 1'b0});
			attr_byte <= {3'h0, a[2], a[1], 3'h5};
			ext_font_plane_sel <= {a[0], a[1]}; // both select bits vary
			repeat (3) @(posedge mclk);
			chk({5'h0, font_block}, {5'h0, blk[(a[0] && !a[1]) ? b : a]});
			chk({6'h0, font_plane, mem_extended}, {6'h0, a[2] ? a[0] : a[1], a[0]});
		end
		sr(IDX_FONT_SEL, FONT_SEL_RST);
		sr(IDX_MEM_MODE, MEM_MODE_RST);
	endtask : t_fonts
	// each reset bit alone halts; screen off blanks a running sequencer
	task automatic t_run();
		logic [7:0] t [4] = '{8'h02, 8'h03, 8'h01, 8'h03};
		logic [7:0] e [4] = '{8'h01, 8'h06, 8'h01, 8'h07};
		for (int i = 0; i < 4; i++) begin
			sr(IDX_RESET_CTRL, t[i]);
			if (i == 3) begin
				sr(IDX_CLK_MODE, 8'h20);
			end
			repeat (24) @(posedge mclk);
			chk({5'h0, dot_tick, seq_running, screen_blank}, e[i]);
		end
		sr(IDX_CLK_MODE, CLK_MODE_RST);
	endtask : t_run
	////////////////////////////////////////
	// verdict and end of run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	// hang guard
	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		print_verdict();
	end
	// reset, then the scenarios
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		cpu_mem_wr = 1'b0;
		vmem_addr_lo = 2'h0;
		attr_byte = 8'h00;
		ext_font_plane_sel = 2'h0;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		t_regs();
		t_planes();
		t_clocks();
		t_fonts();
		t_run();
		print_verdict();
	end
endmodule : testbench
